/* File: shared/ispe_pkg.sv */
// constants and carrier types for the i2c slave port engine
// assumes a single 10 MHz clock and synchronous active-low reset
// Notes on behaviour
// - no function until port enable bit set; start and stop still set the interrupt flag in the SP and master modes
// - four-bit mode field selects operating mode
// - pins open-drain, driven only when needed
// - match or data byte: ack and load buffer
// - full or overflow: no ack, no load, flag
// - buffer read clears full; overflow cleared by software
// - after start shift eight bits on scl rise
// - compare bits seven to one at eighth fall
// - match: load, full, ack, interrupt at ninth fall
// - ten-bit first byte is 11110 A9 A8 0
// - ten-bit byte sets update flag, stretches scl
// - write match clears direction, buffers address
// - read match sets direction, acks, stretches scl
// - transmit bits change on falling scl
// - master nack at ninth rise ends transfer
// - general call matches all-zero write address
// - ten-bit general call skips update flag
// - reset or disable clears start and stop bits
// - master mode flags start and stop only, no bytes or ack
package ispe_pkg;
	localparam int CON1_MODE_LSB = 0;
	localparam int CON1_CLKREL_BIT = 4;
	localparam int CON1_EN_BIT = 5;
	localparam int CON1_OVF_BIT = 6;
	localparam int CON2_GENERAL_CALL_ENABLE_BIT = 7;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_FWMASTER = 4'hB;
	localparam logic [3:0] MODE_SLV7_SP = 4'hE;
	localparam logic [3:0] MODE_SLV10_SP = 4'hF;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam logic [7:0] GCALL_ADDR = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] ADDR_RESET = 8'h00;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic scl_rise;
		logic scl_fall;
		logic scl;
		logic sda;
	} ispe_bus_ev_t;

	typedef struct packed {
		logic direction;
		logic update_needed;
		logic start_bit;
		logic stop_bit;
		logic buffer_full_flag;
	} ispe_status_t;
endpackage

/* File: rtl/ispe_line_sync.sv */
// synchroniser and start/stop detector for scl and sda
// assumes pins open-drain with external pull-ups
`timescale 1ns/1ns
module ispe_line_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	// events
	output ispe_pkg::ispe_bus_ev_t ev
);
	logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
	logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;

	always_comb begin
		scl_s_d = {scl_s_q[0], scl_in};
		sda_s_d = {sda_s_q[0], sda_in};
		scl_p_d = scl_s_q[1];
		sda_p_d = sda_s_q[1];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= scl_s_d;
			sda_s_q <= sda_s_d;
			scl_p_q <= scl_p_d;
			sda_p_q <= sda_p_d;
		end
	end

	// sda edge while scl held high
	assign ev.start_seen = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
	assign ev.stop_seen = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];
	assign ev.scl_rise = scl_s_q[1] && !scl_p_q;
	assign ev.scl_fall = !scl_s_q[1] && scl_p_q;
	assign ev.scl = scl_s_q[1];
	assign ev.sda = sda_s_q[1];
endmodule // ispe_line_sync

/* File: rtl/ispe_skid_buf.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock; drain side may stall
`timescale 1ns/1ns
module ispe_skid_buf (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	logic [7:0] mem_q [2];
	logic [7:0] mem_d [2];
	logic rd_q, rd_d, wr_q, wr_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop, rdy_q;

	// registered so the ready output comes straight from a flop
	assign in_ready = rdy_q;
	assign out_valid = cnt_q != 2'h0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_q] = in_data;
		end
		wr_d = push ? !wr_q : wr_q;
		rd_d = pop ? !rd_q : rd_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
		if (flush) begin
			wr_d = 1'b0;
			rd_d = 1'b0;
			cnt_d = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
			rdy_q <= 1'b1;
			mem_q[0] <= 8'h00;
			mem_q[1] <= 8'h00;
		end else begin
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
			rdy_q <= cnt_d != 2'h2;
			mem_q <= mem_d;
		end
	end
endmodule // ispe_skid_buf

/* File: rtl/ispe_slave_engine.sv */
// i2c slave engine: address match, ack, stretch, transmit
// assumes software strobes are one-cycle pulses on clk
`timescale 1ns/1ns
module ispe_slave_engine (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control bits
	input wire logic [7:0] control_reg_one,
	input wire logic [7:0] control_reg_two,
	input wire logic [1:0] pin_direction_reg,
	input wire logic [7:0] own_address_wdata,
	input wire logic own_address_wr,
	input wire logic overflow_clear,
	input wire logic clock_release_set,
	input wire logic irq_flag_clear,
	// transfer buffer
	input wire logic buffer_rd,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] transfer_buffer,
	// status
	output ispe_pkg::ispe_status_t port_status_reg,
	output logic receive_overflow_flag,
	output logic port_interrupt_flag,
	output logic clock_release_bit,
	output logic [7:0] own_address_reg,
	// pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RXBITS = 6'h02,
		ST_ACK = 6'h04,
		ST_TXBITS = 6'h08,
		ST_TXACK = 6'h10,
		ST_STRETCH = 6'h20
	} ispe_state_t;

	ispe_pkg::ispe_bus_ev_t ev;
	ispe_state_t st_q, st_d;
	logic [7:0] sr_q, sr_d, buf_q, buf_d, adr_q, adr_d;
	logic [3:0] bit_q, bit_d;
	logic full_q, full_d, ovf_q, ovf_d, irq_q, irq_d, ckp_q, ckp_d;
	logic dir_q, dir_d, ua_q, ua_d, s_q, s_d, p_q, p_d;
	logic ack_q, ack_d, addr_ph_q, addr_ph_d, hi_ok_q, hi_ok_d;
	logic sda_lo_q, sda_lo_d, scl_lo_q, scl_lo_d, sda_oe_q, scl_oe_q;
	logic enabled, i2c_mode, slave_mode, ten_bit, sp_irq, pins_in;
	logic match7, match10hi, match10lo, gcall, hit;
	logic tb_valid, tb_pop;
	logic [7:0] tb_data;

	ispe_line_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev)
	);

	// transmit words wait here until the stretch ends
	ispe_skid_buf u_txbuf (
		.clk(clk),
		.rst_n(rst_n),
		.flush(!enabled),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(tb_valid),
		.out_ready(tb_pop),
		.out_data(tb_data)
	);

	function automatic logic is_mode(input logic [3:0] m, input logic [3:0] v);
		return m == v;
	endfunction

	wire [3:0] mode = control_reg_one[ispe_pkg::CON1_MODE_LSB +: 4];
	assign enabled = control_reg_one[ispe_pkg::CON1_EN_BIT];
	assign ten_bit = is_mode(mode, ispe_pkg::MODE_SLV10)
		|| is_mode(mode, ispe_pkg::MODE_SLV10_SP);
	assign sp_irq = is_mode(mode, ispe_pkg::MODE_SLV7_SP)
		|| is_mode(mode, ispe_pkg::MODE_SLV10_SP)
		|| is_mode(mode, ispe_pkg::MODE_MASTER)
		|| is_mode(mode, ispe_pkg::MODE_FWMASTER);
	assign slave_mode = ten_bit || sp_irq && !is_mode(mode,
		ispe_pkg::MODE_MASTER) && !is_mode(mode, ispe_pkg::MODE_FWMASTER)
		|| is_mode(mode, ispe_pkg::MODE_SLV7);
	assign i2c_mode = slave_mode || is_mode(mode, ispe_pkg::MODE_MASTER)
		|| is_mode(mode, ispe_pkg::MODE_FWMASTER);
	assign pins_in = &pin_direction_reg;
	assign tb_pop = 1'b0 || (st_q == ST_STRETCH && clock_release_set
		&& dir_q);

	assign match7 = sr_q[7:1] == adr_q[7:1];
	assign match10hi = sr_q[7:3] == ispe_pkg::TEN_BIT_PREFIX
		&& sr_q[2:1] == adr_q[2:1];
	assign match10lo = sr_q == adr_q && hi_ok_q;
	assign gcall = control_reg_two[ispe_pkg::CON2_GENERAL_CALL_ENABLE_BIT]
		&& sr_q == ispe_pkg::GCALL_ADDR;
	assign hit = gcall || (ten_bit ? (match10hi && !sr_q[0] || match10lo)
		: match7);

	always_comb begin
		st_d = st_q;
		sr_d = sr_q;
		buf_d = buf_q;
		adr_d = own_address_wr ? own_address_wdata : adr_q;
		bit_d = bit_q;
		full_d = buffer_rd ? 1'b0 : full_q;
		ovf_d = overflow_clear ? 1'b0 : ovf_q;
		irq_d = irq_flag_clear ? 1'b0 : irq_q;
		ckp_d = clock_release_set ? 1'b1 : ckp_q;
		dir_d = dir_q;
		ua_d = own_address_wr ? 1'b0 : ua_q;
		s_d = s_q;
		p_d = p_q;
		ack_d = ack_q;
		addr_ph_d = addr_ph_q;
		hi_ok_d = hi_ok_q;
		sda_lo_d = sda_lo_q;
		scl_lo_d = scl_lo_q && !own_address_wr && !clock_release_set;
		if (ev.start_seen) begin
			s_d = 1'b1;
			p_d = 1'b0;
			if (sp_irq) begin
				irq_d = 1'b1;
			end
		end
		if (ev.stop_seen) begin
			p_d = 1'b1;
			s_d = 1'b0;
			if (sp_irq) begin
				irq_d = 1'b1;
			end
		end
		case (st_q)
			ST_IDLE: begin
			end
			ST_RXBITS: begin
				if (ev.scl_rise) begin
					sr_d = {sr_q[6:0], ev.sda};
					bit_d = bit_q + 4'h1;
				end
				if (ev.scl_fall && bit_q == ispe_pkg::BITS_PER_BYTE) begin
					ack_d = addr_ph_q ? hit : 1'b1;
					if (ack_d && (full_q || ovf_q)) begin
						ack_d = 1'b0;
						ovf_d = 1'b1;
						irq_d = 1'b1;
					end else if (ack_d) begin
						buf_d = sr_q;
						full_d = 1'b1;
						sda_lo_d = 1'b1;
						if (addr_ph_q) begin
							dir_d = sr_q[0] && !gcall;
						end
					end
					st_d = ack_d || (full_q || ovf_q) && (!addr_ph_q || hit)
						? ST_ACK : ST_IDLE;
					if (!ack_d && !(addr_ph_q && hit)) begin
						st_d = addr_ph_q ? ST_IDLE : ST_ACK;
					end
				end
			end
			ST_ACK: begin
				if (ev.scl_fall) begin
					sda_lo_d = 1'b0;
					bit_d = 4'h0;
					irq_d = 1'b1;
					st_d = ST_RXBITS;
					if (ack_q && addr_ph_q) begin
						if (ten_bit && !gcall && !(match10hi && dir_q)) begin
							ua_d = 1'b1;
							scl_lo_d = 1'b1;
							hi_ok_d = match10hi;
							addr_ph_d = match10hi;
						end else begin
							addr_ph_d = 1'b0;
						end
						if (dir_q) begin
							ckp_d = 1'b0;
							scl_lo_d = 1'b1;
							st_d = ST_STRETCH;
						end
					end
				end
			end
			ST_STRETCH: begin
				if (ckp_d && tb_valid) begin
					sr_d = tb_data;
					scl_lo_d = 1'b0;
					sda_lo_d = !tb_data[7];
					bit_d = 4'h0;
					st_d = ST_TXBITS;
				end
			end
			ST_TXBITS: begin
				if (ev.scl_fall) begin
					bit_d = bit_q + 4'h1;
					sr_d = {sr_q[6:0], 1'b0};
					sda_lo_d = bit_q != 4'h7 && !sr_q[6];
					if (bit_q == 4'h7) begin
						st_d = ST_TXACK;
					end
				end
			end
			ST_TXACK: begin
				if (ev.scl_rise) begin
					if (ev.sda) begin
						st_d = ST_IDLE;
						dir_d = 1'b0;
						full_d = 1'b0;
						ua_d = 1'b0;
					end else begin
						st_d = ST_ACK;
						dir_d = 1'b1;
						ack_d = 1'b1;
						addr_ph_d = 1'b1;
						hi_ok_d = 1'b0;
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (ev.start_seen && slave_mode) begin
			st_d = ST_RXBITS;
			bit_d = 4'h0;
			addr_ph_d = 1'b1;
			sda_lo_d = 1'b0;
			scl_lo_d = 1'b0;
		end
		if (ev.stop_seen) begin
			st_d = ST_IDLE;
			sda_lo_d = 1'b0;
			scl_lo_d = 1'b0;
			hi_ok_d = 1'b0;
		end
		if (!enabled || !slave_mode) begin
			st_d = ST_IDLE;
			sda_lo_d = 1'b0;
			scl_lo_d = 1'b0;
		end
		if (!enabled) begin
			s_d = 1'b0;
			p_d = 1'b0;
		end
		if (buffer_rd) begin
			full_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			sr_q <= 8'h00;
			buf_q <= 8'h00;
			adr_q <= ispe_pkg::ADDR_RESET;
			bit_q <= 4'h0;
			{full_q, ovf_q, irq_q, ckp_q, dir_q, ua_q} <= 6'h00;
			{s_q, p_q, ack_q, addr_ph_q, hi_ok_q} <= 5'h00;
			{sda_lo_q, scl_lo_q, sda_oe_q, scl_oe_q} <= 4'h0;
		end else begin
			st_q <= st_d;
			sr_q <= sr_d;
			buf_q <= buf_d;
			adr_q <= adr_d;
			bit_q <= bit_d;
			{full_q, ovf_q, irq_q, ckp_q, dir_q, ua_q} <=
				{full_d, ovf_d, irq_d, ckp_d, dir_d, ua_d};
			{s_q, p_q, ack_q, addr_ph_q, hi_ok_q} <=
				{s_d, p_d, ack_d, addr_ph_d, hi_ok_d};
			{sda_lo_q, scl_lo_q} <= {sda_lo_d, scl_lo_d};
			sda_oe_q <= sda_lo_d && enabled && i2c_mode && pins_in;
			scl_oe_q <= scl_lo_d && enabled && i2c_mode && pins_in;
		end
	end

	assign transfer_buffer = buf_q;
	assign port_status_reg = '{direction: dir_q, update_needed: ua_q,
		start_bit: s_q, stop_bit: p_q, buffer_full_flag: full_q};
	assign receive_overflow_flag = ovf_q;
	assign port_interrupt_flag = irq_q;
	assign clock_release_bit = ckp_q;
	assign own_address_reg = adr_q;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;

	full_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_RXBITS && ev.scl_fall && bit_q == 4'h8
		&& (full_q || ovf_q) && !buffer_rd && !overflow_clear
		&& (!addr_ph_q || hit)
		|=> !sda_lo_q && ovf_q && buf_q == $past(buf_q))
		else $error("ack given while buffer busy");
	read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		buffer_rd |=> !full_q)
		else $error("buffer read left full flag");
	disable_sp_a: assert property (@(posedge clk) disable iff (!rst_n)
		!enabled |=> !s_q && !p_q && !sda_oe_q && !scl_oe_q)
		else $error("disabled port kept state");
	ua_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		own_address_wr && !ev.start_seen |=> !ua_q)
		else $error("address write left update flag");
	nack_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_TXACK && ev.scl_rise && ev.sda && enabled && slave_mode
		&& !ev.start_seen |=> st_q == ST_IDLE && !dir_q)
		else $error("nack did not end transfer");
	start_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
		ev.start_seen && enabled && slave_mode && !ev.stop_seen
		|=> st_q == ST_RXBITS && bit_q == 4'h0)
		else $error("start not followed by receive");
	stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_STRETCH && !clock_release_set && enabled && slave_mode
		&& !ev.stop_seen && !ev.start_seen |=> st_q == ST_STRETCH)
		else $error("stretch ended without release");
	gc_no_ua_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_ACK && ev.scl_fall && gcall && addr_ph_q && !ua_q
		&& !ev.start_seen |=> !ua_q)
		else $error("general call set update flag");
	addr_cov_c: cover property (@(posedge clk) st_q == ST_ACK && ack_q);
	tx_cov_c: cover property (@(posedge clk) st_q == ST_TXBITS);
	ua_cov_c: cover property (@(posedge clk) ua_q);
endmodule // ispe_slave_engine

/* File: testbench/ispe_master_model.sv */
// i2c bus master model, drives scl and sda low or releases them
// assumes pull-ups in the bench; scl high for about H clk cycles, low for about 2H
`timescale 1ns/1ns
module ispe_master_model #(parameter int H = 20) (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	int timeouts = 0;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic half;
		repeat (H) @(posedge clk);
	endtask
	// release scl, then wait out any stretch by the slave
	task automatic rise;
		int n;
		n = 0;
		@(posedge clk) scl_low <= 1'b0;
		while (scl !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) timeouts++;
		half();
	endtask
	task automatic bit_io(input logic b, output logic s);
		@(posedge clk) sda_low <= !b;
		half();
		rise();
		s = sda;
		@(posedge clk) scl_low <= 1'b1;
		half();
	endtask
	task automatic start_c;
		@(posedge clk) sda_low <= 1'b0;
		half();
		rise();
		@(posedge clk) sda_low <= 1'b1;
		half();
		@(posedge clk) scl_low <= 1'b1;
		half();
	endtask
	task automatic stop_c;
		@(posedge clk) sda_low <= 1'b1;
		half();
		rise();
		@(posedge clk) sda_low <= 1'b0;
		half();
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic get_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(nack, s);
	endtask
endmodule // ispe_master_model

/* File: testbench/tb.sv */
// self-checking bench for the i2c slave engine
// assumes pull-ups on both lines and the master model as the far side
`timescale 1ns/1ns
module tb;
	logic clk, rst_n, awr, txv, txr, ack, ovf, irq, rel;
	logic [7:0] con1, con2, awd, txd, rbuf, tbuf, own;
	logic [3:0] stb;
	logic [1:0] pdir;
	logic scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
	ispe_pkg::ispe_status_t st;
	wire logic scl = !((scl_oe && !scl_o) || m_scl);
	wire logic sda = !((sda_oe && !sda_o) || m_sda);
	int mismatches = 0;
	int compares = 0;
	logic [3:0] modes [4] = '{ispe_pkg::MODE_SLV7, ispe_pkg::MODE_SLV7_SP,
		ispe_pkg::MODE_MASTER, ispe_pkg::MODE_FWMASTER};
	ispe_slave_engine DUT (
		.clk(clk), .rst_n(rst_n),
		.control_reg_one(con1), .control_reg_two(con2),
		.pin_direction_reg(pdir),
		.own_address_wdata(awd), .own_address_wr(awr),
		.overflow_clear(stb[2]), .clock_release_set(stb[3]),
		.irq_flag_clear(stb[1]), .buffer_rd(stb[0]),
		.tx_data(txd), .tx_valid(txv), .tx_ready(txr),
		.transfer_buffer(tbuf), .port_status_reg(st),
		.receive_overflow_flag(ovf), .port_interrupt_flag(irq),
		.clock_release_bit(rel), .own_address_reg(own),
		.scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe(scl_oe),
		.sda_out(sda_o), .sda_oe(sda_oe)
	);
	ispe_master_model M (
		.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_n, awr, txv} = 3'h0;
		{con1, con2, awd, txd} = 32'h0;
		stb = 4'h0;
		pdir = 2'h3;
	end
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// bit0 read, bit1 irq clear, bit2 overflow clear, bit3 release
	task automatic strobe(input logic [3:0] s);
		@(posedge clk) stb <= s;
		@(posedge clk) stb <= 4'h0;
		// let the flags settle before any compare
		@(posedge clk);
	endtask
	task automatic set_own(input logic [7:0] a);
		@(posedge clk) {awr, awd} <= {1'b1, a};
		@(posedge clk) awr <= 1'b0;
	endtask
	task automatic load_tx(input logic [7:0] d);
		@(posedge clk) {txv, txd} <= {1'b1, d};
		do @(posedge clk); while (txr !== 1'b1);
		txv <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] b, input logic exp_ack);
		M.put_byte(b, ack);
		repeat (5) @(posedge clk);
		chk_bit(ack, exp_ack, "ack");
	endtask
	initial begin
		#5_000_000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		set_own(8'hA0);
		M.start_c();
		xfer(8'hA0, 1'b0);
		M.stop_c();
		chk_bit(st.stop_bit, 1'b0, "stop bit while off");
		con1 <= {4'h2, ispe_pkg::MODE_SLV7};
		pdir <= 2'h0;
		M.start_c();
		xfer(8'hA0, 1'b0);
		M.stop_c();
		chk_bit(scl_o || sda_o, 1'b0, "open drain low");
		strobe(4'h3);
		pdir <= 2'h3;
		foreach (modes[i]) begin
			con1 <= {4'h2, modes[i]};
			M.start_c();
			xfer(8'hA0, 1'(i < 2));
			M.stop_c();
			strobe(4'h3);
		end
		con1 <= {4'h2, ispe_pkg::MODE_SLV7};
		M.start_c();
		xfer(8'hA0, 1'b1);
		chk_byte(tbuf, 8'hA0, "address in buffer");
		chk_bit(st.buffer_full_flag, 1'b1, "full");
		chk_bit(irq, 1'b1, "irq");
		chk_bit(st.direction, 1'b0, "write dir");
		chk_bit(st.start_bit, 1'b1, "start seen");
		strobe(4'h2);
		xfer(8'h5A, 1'b0);
		chk_byte(tbuf, 8'hA0, "buffer kept");
		chk_bit(ovf, 1'b1, "overflow");
		chk_bit(irq, 1'b1, "irq on refusal");
		strobe(4'h1);
		chk_bit(st.buffer_full_flag, 1'b0, "read clears full");
		chk_bit(ovf, 1'b1, "overflow sticky");
		xfer(8'h11, 1'b0);
		strobe(4'h4);
		xfer(8'h22, 1'b1);
		chk_byte(tbuf, 8'h22, "data byte");
		M.stop_c();
		chk_bit(st.stop_bit, 1'b1, "stop seen");
		strobe(4'h3);
		M.start_c();
		xfer(8'h42, 1'b0);
		M.start_c();
		xfer(8'h00, 1'b0);
		con2 <= 8'h80;
		M.start_c();
		xfer(8'h00, 1'b1);
		chk_byte(tbuf, 8'h00, "general call");
		M.stop_c();
		strobe(4'h3);
		M.start_c();
		xfer(8'hA1, 1'b1);
		chk_bit(st.direction, 1'b1, "read dir");
		chk_bit(rel, 1'b0, "clock held");
		repeat (20) @(posedge clk);
		chk_bit(scl, 1'b0, "stretch");
		load_tx(8'hC3);
		load_tx(8'h3C);
		@(posedge clk);
		chk_bit(txr, 1'b0, "tx buffer full");
		strobe(4'h8);
		chk_bit(rel, 1'b1, "clock released");
		M.get_byte(1'b0, rbuf);
		chk_byte(rbuf, 8'hC3, "first sent");
		chk_bit(rel, 1'b0, "held after ack");
		strobe(4'h8);
		M.get_byte(1'b1, rbuf);
		repeat (5) @(posedge clk);
		chk_byte(rbuf, 8'h3C, "second sent");
		chk_bit(st.direction, 1'b0, "nack ends");
		chk_bit(txr, 1'b1, "tx buffer empty");
		M.stop_c();
		strobe(4'h3);
		con1 <= {4'h2, ispe_pkg::MODE_SLV10};
		set_own(8'hF2);
		M.start_c();
		xfer(8'hF2, 1'b1);
		chk_bit(st.update_needed, 1'b1, "update");
		repeat (20) @(posedge clk);
		chk_bit(scl, 1'b0, "hold for update");
		set_own(8'h34);
		strobe(4'h3);
		chk_bit(st.update_needed, 1'b0, "update cleared");
		chk_byte(own, 8'h34, "own address");
		xfer(8'h34, 1'b1);
		chk_bit(st.update_needed, 1'b1, "update again");
		set_own(8'hF2);
		strobe(4'h3);
		M.stop_c();
		con1 <= {4'h2, ispe_pkg::MODE_SLV10_SP};
		strobe(4'h3);
		M.start_c();
		chk_bit(irq, 1'b1, "start irq");
		xfer(8'h00, 1'b1);
		chk_bit(st.update_needed, 1'b0, "general call no update");
		strobe(4'h3);
		M.stop_c();
		chk_bit(irq, 1'b1, "stop irq");
		strobe(4'h3);
		con1 <= {4'h0, ispe_pkg::MODE_SLV10};
		repeat (5) @(posedge clk);
		chk_bit(st.stop_bit, 1'b0, "disable clears stop");
		chk_bit(st.start_bit, 1'b0, "disable clears start");
		chk_bit(1'(M.timeouts == 0), 1'b1, "stretch bounded");
		stop_test();
	end
endmodule // tb
